// >>> design/clock_startup_pkg.sv
// Shared constants and types of the clock source and start-up controller.
// Assumes a single APB clock pclk at 10 MHz and oscillators seen as plain pins.
package clock_startup_pkg;

	// APB register byte offsets
	localparam logic [7:0] FUSE_OFS   = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] CLKEN_OFS  = 8'h08;

	// Configuration bit positions inside the fuse register
	localparam int CLOCK_SOURCE_SELECT_POS = 0;
	localparam int SUT_POS   = 4;
	localparam int DIV8_POS  = 6;

	// Delivered configuration: calibrated RC, start-up 10, divide by eight programmed
	localparam logic [3:0] CLOCK_SOURCE_SELECT_RST = 4'h2;
	localparam logic [1:0] SUT_RST   = 2'h2;
	localparam logic       DIV8_RST  = 1'b0;

	// Time-out delay lengths in watchdog oscillator cycles
	localparam int TOUT_NONE  = 0;
	localparam int TOUT_SHORT = 512;
	localparam int TOUT_LONG  = 8192;

	// Oscillator start-up lengths in oscillator cycles
	localparam int START_EXT = 6;
	localparam int START_258 = 258;
	localparam int START_1K  = 1024;
	localparam int START_16K = 16384;
	localparam int START_32K = 32768;

	// Counter width for the longest count
	localparam int CNT_W = 16;

	// Clock source types, also the index into the oscillator pin vector
	typedef enum logic [2:0] {
		SRC_LP    = 3'h0,
		SRC_FS    = 3'h1,
		SRC_LF    = 3'h2,
		SRC_RC128 = 3'h3,
		SRC_RC8   = 3'h4,
		SRC_EXT   = 3'h5
	} src_t;

	// Sleep modes reported by the sleep controller
	typedef enum logic [2:0] {
		SLP_IDLE     = 3'h1,
		SLP_ADC_NR   = 3'h2,
		SLP_PWR_DOWN = 3'h3,
		SLP_PWR_SAVE = 3'h4,
		SLP_STANDBY  = 3'h5,
		SLP_EXT_STBY = 3'h6
	} sleep_mode_t;

	// Start-up phases, one-hot
	typedef enum logic [5:0] {
		ST_RESET = 6'h01,
		ST_TOUT  = 6'h02,
		ST_START = 6'h04,
		ST_RUN   = 6'h08,
		ST_SLEEP = 6'h10,
		ST_WAKE  = 6'h20
	} phase_t;

	// Configuration bits, 1 unprogrammed, 0 programmed
	typedef struct packed {
		logic       div8;
		logic [1:0] startup_time_select;
		logic [3:0] clock_source_select;
	} fuse_t;

	// Clock domain run enables
	typedef struct packed {
		logic core;
		logic periph;
		logic flash;
		logic async_tmr;
		logic conv;
	} clk_en_t;

endpackage : clock_startup_pkg

// >>> design/pin_sync.sv
// Three-stage synchroniser for a pin from outside the pclk domain.
// Assumes the pin may change at any time; a change counts once stages two and three agree.
module pin_sync
	import clock_startup_pkg::*;
(
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic din,
	output logic      level,
	output logic      rise
);

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
	} sync_t;

	sync_t sync_ff;
	sync_t nxt_sync;

	// Shift the pin and accept a level once two stages agree
	always_comb begin
		nxt_sync    = sync_ff;
		nxt_sync.s1 = din;
		nxt_sync.s2 = sync_ff.s1;
		nxt_sync.s3 = sync_ff.s2;
		if (sync_ff.s2 == sync_ff.s3) begin
			nxt_sync.lvl = sync_ff.s3;
		end
	end

	// Stages start high so a reset pin held through power-up is seen as asserted
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_ff <= '1;
		end else begin
			sync_ff <= nxt_sync;
		end
	end

	// Accepted level and a one-cycle pulse on its rising change
	assign level = sync_ff.lvl;
	assign rise  = sync_ff.s2 & sync_ff.s3 & ~sync_ff.lvl;

endmodule : pin_sync

// >>> design/cycle_counter.sv
// Terminal counter of synchronised oscillator cycles, restarted by clear.
// Assumes tick is a one-cycle pulse per oscillator cycle; target may be zero.
module cycle_counter
	import clock_startup_pkg::*;
#(
	parameter int W = CNT_W
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         clear,
	input  wire logic         tick,
	input  wire logic [W-1:0] target,
	output logic              done
);

	// The count must fit a sensible counter
	if (W < 2 || W > 32) begin : g_chk
		$error("counter width out of range");
	end

	typedef struct packed {
		logic [W-1:0] cnt;
	} cnt_t;

	cnt_t cnt_ff;
	cnt_t nxt_cnt;

	// Count ticks until the target is reached, then hold
	always_comb begin
		nxt_cnt = cnt_ff;
		if (clear) begin
			nxt_cnt.cnt = '0;
		end else if (tick && !done) begin
			nxt_cnt.cnt = cnt_ff.cnt + 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff <= '0;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end

	assign done = (cnt_ff.cnt >= target);

endmodule : cycle_counter

// >>> design/clock_source_startup_control.sv
// Clock source selection, start-up reset sequencing and clock domain gating.
// Assumes APB master on pclk, sleep controller signals on pclk, oscillators as pins.
// Functional notes
// - Clocks of unused domains are stopped according to the sleep mode.
// - Core clock runs only when awake and out of reset.
// - Peripheral clock feeds timers, serial units and external interrupts.
// - Serial start detection goes asynchronous while peripheral clock stops; address match always.
// - Wake from level stays a wake; interrupt only if level still held.
// - Program memory clock runs together with the core clock.
// - Asynchronous timer clock keeps running through power-save sleep.
// - Converter and asynchronous timer clocks run on in converter noise reduction sleep.
// - Source codes 1111-1000 low power, 0111-0110 full swing, 0101-0100 low frequency.
// - Code 0011 128 kHz RC, 0010 calibrated RC, 0000 external; 0001 reserved.
// - Configuration bits read 1 unprogrammed, 0 programmed.
// - Delivered setting is calibrated RC, start-up 10, divide by eight on.
// - Internal reset stays on for a time-out after other resets release.
// - Time-out counts 0, 512 or 8192 watchdog cycles per settings.
// - Start-up counter counts selected oscillator cycles before releasing reset.
// - Start-up count ranges from 6 to 32K cycles by clock type.
// - Reset start uses time-out plus start-up; power-save/down wake uses start-up only.
module clock_source_startup_control
	import clock_startup_pkg::*;
#(
	parameter int TOUT_LONG_CYC = TOUT_LONG,
	parameter int START_16K_CYC = START_16K,
	parameter int START_32K_CYC = START_32K
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [7:0]   paddr,
	input  wire logic [31:0]  pwdata,
	output logic [31:0]       prdata,
	output logic              pready,
	output logic              pslverr,
	input  wire logic         ext_reset_req,
	input  wire logic         wdt_osc,
	input  wire logic [5:0]   osc_in,
	input  wire logic         level_irq_in,
	input  wire logic         sleep_en,
	input  wire sleep_mode_t  sleep_mode,
	input  wire logic         wake_req,
	output logic              sys_reset_n,
	output clk_en_t           clk_en,
	output logic              div8_active,
	output logic              wake_irq,
	output logic              usu_async_start_en,
	output logic              twu_addr_match_en
);

	// Counts must fit the counter
	if (TOUT_LONG_CYC < 1 || TOUT_LONG_CYC > 65535 || START_16K_CYC < 1 ||
		START_16K_CYC > 65535 || START_32K_CYC < 1 || START_32K_CYC > 65535) begin : g_chk
		$error("cycle count parameter out of counter range");
	end

	typedef struct packed {
		phase_t      st;
		fuse_t       fuse;
		fuse_t       cfg;
		clk_en_t     en;
		logic        rst_n;
		logic        div8;
		logic        irq;
		logic        usu;
		logic        twu;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} ctl_t;

	ctl_t ctl_ff;
	ctl_t nxt_ctl;

	logic             ext_lvl;
	logic             irq_lvl;
	logic             wdt_rise;
	logic             osc_rise;
	logic             osc_pin;
	logic             tout_done;
	logic             start_done;
	logic [CNT_W-1:0] tout_target;
	logic [CNT_W-1:0] start_target;
	src_t             src;
	phase_t           st_q;

	assign st_q = ctl_ff.st;

	// Decode the source type from the latched select code
	always_comb begin
		casez (ctl_ff.cfg.clock_source_select)
			4'b1???: src = SRC_LP;
			4'b011?: src = SRC_FS;
			4'b010?: src = SRC_LF;
			4'b0011: src = SRC_RC128;
			4'b0000: src = SRC_EXT;
			default: src = SRC_RC8;                     // Reserved code falls back to RC
		endcase
	end

	// Pick time-out and start-up lengths from start-up and select bits
	always_comb begin
		tout_target  = '0;
		start_target = CNT_W'(START_EXT);
		if (src == SRC_LP || src == SRC_FS) begin
			case ({ctl_ff.cfg.clock_source_select[0], ctl_ff.cfg.startup_time_select})
				3'h0: tout_target = CNT_W'(TOUT_SHORT);
				3'h1: tout_target = CNT_W'(TOUT_LONG_CYC);
				3'h2: tout_target = CNT_W'(TOUT_NONE);
				3'h3: tout_target = CNT_W'(TOUT_SHORT);
				3'h4: tout_target = CNT_W'(TOUT_LONG_CYC);
				3'h5: tout_target = CNT_W'(TOUT_NONE);
				3'h6: tout_target = CNT_W'(TOUT_SHORT);
				default: tout_target = CNT_W'(TOUT_LONG_CYC);
			endcase
			case ({ctl_ff.cfg.clock_source_select[0], ctl_ff.cfg.startup_time_select})
				3'h0, 3'h1: start_target = CNT_W'(START_258);
				3'h2, 3'h3, 3'h4: start_target = CNT_W'(START_1K);
				default: start_target = CNT_W'(START_16K_CYC);
			endcase
		end else begin
			case (ctl_ff.cfg.startup_time_select)
				2'h0: tout_target = CNT_W'(TOUT_NONE);
				2'h1: tout_target = CNT_W'(TOUT_SHORT);
				default: tout_target = CNT_W'(TOUT_LONG_CYC);
			endcase
			if (src == SRC_LF) begin
				start_target = CNT_W'(START_32K_CYC);
			end else begin
				start_target = CNT_W'(START_EXT);
			end
		end
	end

	// Selected oscillator pin
	assign osc_pin = osc_in[src];

	// Pins from outside the pclk domain
	pin_sync u_sync_ext (
		.pclk    (pclk),
		.presetn (presetn),
		.din     (ext_reset_req),
		.level   (ext_lvl),
		.rise    ()
	);

	pin_sync u_sync_irq (
		.pclk    (pclk),
		.presetn (presetn),
		.din     (level_irq_in),
		.level   (irq_lvl),
		.rise    ()
	);

	pin_sync u_sync_wdt (
		.pclk    (pclk),
		.presetn (presetn),
		.din     (wdt_osc),
		.level   (),
		.rise    (wdt_rise)
	);

	pin_sync u_sync_osc (
		.pclk    (pclk),
		.presetn (presetn),
		.din     (osc_pin),
		.level   (),
		.rise    (osc_rise)
	);

	// Time-out on watchdog cycles, then ripple start-up on the chosen oscillator
	cycle_counter #(.W(CNT_W)) u_tout (
		.pclk    (pclk),
		.presetn (presetn),
		.clear   (ctl_ff.st != ST_TOUT),
		.tick    (wdt_rise),
		.target  (tout_target),
		.done    (tout_done)
	);

	cycle_counter #(.W(CNT_W)) u_start (
		.pclk    (pclk),
		.presetn (presetn),
		.clear   (ctl_ff.st != ST_START && ctl_ff.st != ST_WAKE),
		.tick    (osc_rise),
		.target  (start_target),
		.done    (start_done)
	);

	// Sequencer, clock gating and APB slave
	always_comb begin
		nxt_ctl         = ctl_ff;
		nxt_ctl.irq     = 1'b0;
		nxt_ctl.pready  = 1'b0;
		nxt_ctl.pslverr = 1'b0;
		nxt_ctl.twu     = 1'b1;
		case (ctl_ff.st)
			ST_RESET: begin
				nxt_ctl.cfg = ctl_ff.fuse;
				if (!ext_lvl) begin
					nxt_ctl.st = ST_TOUT;
				end
			end
			ST_TOUT: begin
				if (tout_done) begin
					nxt_ctl.st = ST_START;
				end
			end
			ST_START: begin
				if (start_done) begin
					nxt_ctl.st = ST_RUN;
				end
			end
			ST_RUN: begin
				if (sleep_en && (sleep_mode == SLP_PWR_DOWN || sleep_mode == SLP_PWR_SAVE)) begin
					nxt_ctl.st = ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				if (wake_req) begin
					nxt_ctl.st = ST_WAKE;
				end
			end
			ST_WAKE: begin
				if (start_done) begin
					nxt_ctl.st  = ST_RUN;
					nxt_ctl.irq = irq_lvl;
				end
			end
			default: nxt_ctl.st = ST_RESET;
		endcase
		if (ext_lvl) begin
			nxt_ctl.st = ST_RESET;
		end
		// Reset stays released through sleep and the wake start-up
		nxt_ctl.rst_n = (nxt_ctl.st == ST_RUN) || (nxt_ctl.st == ST_SLEEP) ||
			(nxt_ctl.st == ST_WAKE);
		nxt_ctl.div8  = ~ctl_ff.cfg.div8;
		// Domain enables per phase and sleep mode
		nxt_ctl.en = '0;
		if (nxt_ctl.st == ST_RUN) begin
			if (!sleep_en) begin
				nxt_ctl.en = '1;
			end else begin
				case (sleep_mode)
					SLP_IDLE: begin
						nxt_ctl.en.periph    = 1'b1;
						nxt_ctl.en.async_tmr = 1'b1;
						nxt_ctl.en.conv      = 1'b1;
					end
					SLP_ADC_NR: begin
						nxt_ctl.en.async_tmr = 1'b1;
						nxt_ctl.en.conv      = 1'b1;
					end
					SLP_EXT_STBY: nxt_ctl.en.async_tmr = 1'b1;
					default: nxt_ctl.en = '0;
				endcase
			end
		end else if (nxt_ctl.st == ST_SLEEP) begin
			nxt_ctl.en.async_tmr = (sleep_mode == SLP_PWR_SAVE);
		end
		nxt_ctl.usu = ~nxt_ctl.en.periph;
		// APB: answer in the first access cycle
		if (psel && !penable) begin
			nxt_ctl.pready = 1'b1;
			nxt_ctl.prdata = '0;
			case (paddr)
				FUSE_OFS: begin
					nxt_ctl.prdata[6:0] = ctl_ff.fuse;
				end
				STATUS_OFS: begin
					nxt_ctl.prdata[5:0]   = ctl_ff.st;
					nxt_ctl.prdata[10:8]  = src;
					nxt_ctl.prdata[12]    = ctl_ff.rst_n;
					nxt_ctl.prdata[13]    = tout_done;
					nxt_ctl.prdata[14]    = start_done;
				end
				CLKEN_OFS: begin
					nxt_ctl.prdata[4:0] = ctl_ff.en;
					nxt_ctl.prdata[5]   = ctl_ff.div8;
				end
				default: nxt_ctl.pslverr = 1'b1;
			endcase
		end
		// Fuse write lands at the access edge where pready is sampled high
		if (psel && penable && ctl_ff.pready && pwrite && !ctl_ff.pslverr &&
			paddr == FUSE_OFS) begin
			nxt_ctl.fuse = pwdata[DIV8_POS:CLOCK_SOURCE_SELECT_POS];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_ff       <= '0;
			ctl_ff.st    <= ST_RESET;
			ctl_ff.fuse  <= {DIV8_RST, SUT_RST, CLOCK_SOURCE_SELECT_RST};
			ctl_ff.cfg   <= {DIV8_RST, SUT_RST, CLOCK_SOURCE_SELECT_RST};
			ctl_ff.div8  <= 1'b1;
			ctl_ff.twu   <= 1'b1;
			ctl_ff.usu   <= 1'b1;
		end else begin
			ctl_ff <= nxt_ctl;
		end
	end

	// Outputs from flip-flops
	assign prdata             = ctl_ff.prdata;
	assign pready             = ctl_ff.pready;
	assign pslverr            = ctl_ff.pslverr;
	assign sys_reset_n        = ctl_ff.rst_n;
	assign clk_en             = ctl_ff.en;
	assign div8_active        = ctl_ff.div8;
	assign wake_irq           = ctl_ff.irq;
	assign usu_async_start_en = ctl_ff.usu;
	assign twu_addr_match_en  = ctl_ff.twu;

	// Checks
	a_core_in_reset: assert property (@(posedge pclk) disable iff (!presetn)
		!sys_reset_n |-> !clk_en.core) else $error("core clock on in reset");
	a_flash_with_core: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en.flash == clk_en.core) else $error("flash clock differs");
	a_release_sync: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(sys_reset_n) |-> $past(st_q) == ST_START && $past(start_done))
		else $error("reset released early");
	a_tout_first: assert property (@(posedge pclk) disable iff (!presetn)
		(st_q == ST_RESET && !ext_lvl) |=> st_q == ST_TOUT) else $error("no time-out phase");
	a_wake_skips: assert property (@(posedge pclk) disable iff (!presetn)
		(st_q == ST_SLEEP && wake_req && !ext_lvl) |=> st_q == ST_WAKE)
		else $error("wake path wrong");
	a_wake_no_reset: assert property (@(posedge pclk) disable iff (!presetn)
		st_q == ST_WAKE |-> sys_reset_n) else $error("reset asserted during wake");
	a_idle_gates: assert property (@(posedge pclk) disable iff (!presetn)
		(st_q == ST_RUN && sleep_en && sleep_mode == SLP_IDLE && !ext_lvl) |=>
		clk_en.periph && !clk_en.core) else $error("idle gating wrong");
	a_adc_alone: assert property (@(posedge pclk) disable iff (!presetn)
		(st_q == ST_RUN && sleep_en && sleep_mode == SLP_ADC_NR && !ext_lvl) |=>
		clk_en.conv && !clk_en.periph) else $error("converter gating wrong");
	a_async_psave: assert property (@(posedge pclk) disable iff (!presetn)
		(st_q == ST_SLEEP && !wake_req && sleep_mode == SLP_PWR_SAVE && !ext_lvl) |=>
		clk_en.async_tmr) else $error("async timer stopped");
	a_usu_async: assert property (@(posedge pclk) disable iff (!presetn)
		usu_async_start_en == !clk_en.periph) else $error("start detect mode wrong");
	a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
		wake_irq |-> $past(irq_lvl) && $past(st_q) == ST_WAKE) else $error("irq without level");
	c_boot: cover property (@(posedge pclk) disable iff (!presetn) $rose(sys_reset_n));
	c_wake: cover property (@(posedge pclk) disable iff (!presetn) st_q == ST_WAKE ##1 st_q == ST_RUN);
	c_idle: cover property (@(posedge pclk) disable iff (!presetn) sleep_en && clk_en.periph);

endmodule : clock_source_startup_control

// >>> sim/osc_partner.sv
// Behavioural far side: watchdog oscillator and the six selectable clock sources.
// Assumes the bench clock of 100 ns; every source runs slower than a quarter of it.
module osc_partner (
	output logic       wdt_osc,
	output logic [5:0] osc_in
);
	timeunit 1ns;
	timeprecision 1ns;

	// Watchdog oscillator, period 600 ns, free running like the real one
	initial begin
		wdt_osc = 1'b0;
		forever #300 wdt_osc = ~wdt_osc;
	end

	// Source i has period 600 + 100*i ns, so the bench can tell which one is counted
	for (genvar i = 0; i < 6; i++) begin : g_src
		initial begin
			osc_in[i] = 1'b0;
			forever #(300 + 50 * i) osc_in[i] = ~osc_in[i];
		end
	end
endmodule : osc_partner

// >>> sim/clock_source_startup_control_bench.sv
// Self-checking bench of the clock source and start-up controller.
// Assumes the far-side oscillator model and an APB master driven from here.
module clock_source_startup_control_bench
	import clock_startup_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int TL  = 8;
	localparam int S16 = 16;
	localparam int S32 = 32;

	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        ext_reset_req, wdt_osc, level_irq_in, sleep_en, wake_req, er;
	logic [5:0]  osc_in;
	sleep_mode_t sleep_mode;
	logic        sys_reset_n, div8_active, wake_irq, usu_async_start_en, twu_addr_match_en;
	clk_en_t     clk_en;
	int          err_count, n_compared;

	clock_source_startup_control #(.TOUT_LONG_CYC(TL), .START_16K_CYC(S16),
		.START_32K_CYC(S32)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_reset_req(ext_reset_req),
		.wdt_osc(wdt_osc), .osc_in(osc_in), .level_irq_in(level_irq_in),
		.sleep_en(sleep_en), .sleep_mode(sleep_mode), .wake_req(wake_req),
		.sys_reset_n(sys_reset_n), .clk_en(clk_en), .div8_active(div8_active),
		.wake_irq(wake_irq), .usu_async_start_en(usu_async_start_en),
		.twu_addr_match_en(twu_addr_match_en));

	osc_partner osc_u (.wdt_osc(wdt_osc), .osc_in(osc_in));

	// Clock source
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	task automatic close_out;
		if (err_count == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : close_out

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask : wait_cyc

	// One APB transfer; answer taken at the edge where pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
		if (n >= 20)
			check("pready", 1, 0);
	endtask : apb

	// Fuse image, expected time-out and start-up counts, expected source index
	task automatic start_up(input logic [6:0] f, input int tout, input int st, input int src);
		int n;
		int p;
		p = 6 + src;
		ext_reset_req <= 1'b1;
		wait_cyc(8);
		apb(1'b1, FUSE_OFS, {25'h0, f});
		wait_cyc(2);
		apb(1'b0, STATUS_OFS, 32'h0);
		check("source", src, {29'h0, rd[10:8]});
		ext_reset_req <= 1'b0;
		n = 0;
		do begin
			@(negedge pclk);
			n++;
		end while (sys_reset_n !== 1'b1 && n < 40000);
		check("startup_window", 1, n >= tout * 6 + (st - 1) * p - 8 &&
			n <= tout * 6 + (st + 1) * p + 20);
		wait_cyc(3);
		check("clk_en_run", 32'h1F, 32'(clk_en));
		check("div8_active", !f[6], div8_active);
		apb(1'b0, STATUS_OFS, 32'h0);
		check("status_run", 32'h1008 | (tout == 0 ? 32'h2000 : 32'h0), rd & 32'h703F);
		apb(1'b0, CLKEN_OFS, 32'h0);
		check("clken_reg", {26'h0, !f[6], 5'h1F}, rd);
	endtask : start_up

	// Every select code decoded while held in reset
	task automatic src_table;
		int e;
		ext_reset_req <= 1'b1;
		wait_cyc(8);
		for (int c = 0; c < 16; c++) begin
			e = c >= 8 ? 0 : c >= 6 ? 1 : c >= 4 ? 2 : c == 3 ? 3 : c == 0 ? 5 : 4;
			apb(1'b1, FUSE_OFS, 32'h40 | c);
			wait_cyc(2);
			apb(1'b0, STATUS_OFS, 32'h0);
			check("source_code", e, {29'h0, rd[10:8]});
		end
	endtask : src_table

	// Sleep modes that keep the core in its run phase
	task automatic light_sleep;
		sleep_mode_t m[4] = '{SLP_IDLE, SLP_ADC_NR, SLP_STANDBY, SLP_EXT_STBY};
		logic [4:0]  e[4] = '{5'h0B, 5'h03, 5'h00, 5'h02};
		for (int i = 0; i < 4; i++) begin
			sleep_en   <= 1'b1;
			sleep_mode <= m[i];
			wait_cyc(4);
			check("clk_en_sleep", e[i], 32'(clk_en));
			check("usu_async", !e[i][3], usu_async_start_en);
			check("twu_match", 1, twu_addr_match_en);
			sleep_en <= 1'b0;
			wait_cyc(4);
			check("clk_en_back", 32'h1F, 32'(clk_en));
		end
	endtask : light_sleep

	// Power-down or power-save, woken with the level held or dropped
	task automatic deep_sleep(input sleep_mode_t m, input logic lvl, input logic [4:0] e);
		int   n;
		logic seen;
		logic dip;
		sleep_en   <= 1'b1;
		sleep_mode <= m;
		wait_cyc(6);
		check("clk_en_deep", e, 32'(clk_en));
		check("reset_in_sleep", 1, sys_reset_n);
		level_irq_in <= lvl;
		sleep_en     <= 1'b0;
		wake_req     <= 1'b1;
		@(posedge pclk);
		wake_req <= 1'b0;
		n = 0;
		seen = 1'b0;
		dip = 1'b0;
		do begin
			@(negedge pclk);
			n++;
			seen |= wake_irq === 1'b1;
			dip |= sys_reset_n !== 1'b1;
		end while (clk_en.core !== 1'b1 && n < 2000);
		check("reset_in_wake", 0, dip);
		repeat (4) begin
			@(negedge pclk);
			seen |= wake_irq === 1'b1;
		end
		check("wake_no_timeout", 1, n <= 6 * 10 + 24);
		check("wake_irq", lvl, seen);
		level_irq_in <= 1'b0;
		@(posedge pclk);
	endtask : deep_sleep

	// Watchdog against a hang
	initial begin
		#3000000;
		err_count++;
		close_out;
	end

	// Main sequence
	initial begin
		presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
		pwdata = 32'h0; ext_reset_req = 1'b1; level_irq_in = 1'b0; sleep_en = 1'b0;
		sleep_mode = SLP_IDLE; wake_req = 1'b0; err_count = 0; n_compared = 0;
		wait_cyc(4);
		check("reset_out", 32'h0E, {sys_reset_n, div8_active, usu_async_start_en,
			twu_addr_match_en, 1'b0});
		check("clk_en_reset", 32'h0, 32'(clk_en));
		wait_cyc(4);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, FUSE_OFS, 32'h0);
		check("fuse_default", 32'h22, rd);
		apb(1'b1, 8'h0C, 32'h7F);
		check("unmapped_err", 1, er);
		apb(1'b1, 8'h0C, 32'h0);
		check("unmapped_data", 32'h0, rd);
		apb(1'b0, FUSE_OFS, 32'h0);
		check("fuse_kept", 32'h22, rd);
		start_up(7'h22, TL, 6, 4);
		light_sleep;
		deep_sleep(SLP_PWR_DOWN, 1'b1, 5'h00);
		deep_sleep(SLP_PWR_SAVE, 1'b0, 5'h02);
		src_table;
		start_up(7'h40, 0, 6, 5);
		start_up(7'h44, 0, S32, 2);
		start_up(7'h48, 512, 258, 0);
		start_up(7'h57, 0, S16, 1);
		start_up(7'h53, 512, 6, 3);
		close_out;
	end
endmodule : clock_source_startup_control_bench
